/* core/smr_pkg.sv */
// Constants, types and register map of the shared memory refresh engine
package smr_pkg;
  localparam int NCPU = 4;
  localparam int NSET = 4;
  localparam int CW = 12;
  localparam int OW = 14;
  localparam logic [OW-1:0] MAX_CPU_WORDS = 14'h0800;
  localparam logic [OW-1:0] MAX_ALL_WORDS = 14'h2000;
  localparam int BIT_SHIFT = 4;
  localparam logic [3:0] BIT_ALIGN = 4'hf;
  // Register map, word addresses
  localparam logic [15:0] A_CTRL = 16'h0000;
  localparam logic [15:0] A_STAT = 16'h0001;
  localparam logic [15:0] A_CFG = 16'h0010;
  localparam int CFG_SHIFT = 3;
  localparam int DEV_BIT = 15;
  // Status fields
  localparam int S_BUSY = 0;
  localparam int S_PERR = 1;
  localparam int S_WREJ = 2;
  localparam int S_HALT = 4;
  // Config word 0 of a setting
  localparam int C_KIND = 15;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WALK = 2'b01,
    ST_DRAIN = 2'b10
  } smr_state_e;
  typedef struct packed {
    logic is_bit;
    logic [OW:0] base;
    logic [NCPU-1:0][CW-1:0] cnt;
  } smr_cfg_s;
  typedef struct packed {
    logic rd;
    logic [1:0] cpu;
    logic [OW-1:0] addr;
  } smr_req_s;
endpackage

/* core/smr_engine.sv */
// Shared memory auto refresh engine of one CPU
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module smr_engine
  import smr_pkg::*;
#(
  parameter int SELF = 0,
  parameter int DEV_AW = 12,
  parameter int SHM_AW = 13
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic refresh_slot_i,
  input wire logic halt_i,
  input wire logic [NCPU-1:0] peer_halt_i,
  input wire logic [NCPU-1:0][OW-1:0] peer_sum_i,
  output smr_req_s peer_req_o,
  input wire logic [15:0] peer_rdata_i,
  input wire smr_req_s shm_req_i,
  output logic [15:0] shm_rdata_o,
  output logic shm_lock_o,
  output logic [NCPU-1:0] peer_halt_flag_o,
  output logic busy_o,
  output logic param_err_o
);
  // ==========================================
  // Storage
  logic [15:0] dev_mem [2**DEV_AW];
  logic [15:0] shm_mem [2**SHM_AW];
  smr_cfg_s cfg_reg [NSET];
  logic enable_reg;
  logic wrej_reg;
  smr_state_e state_reg;
  logic [1:0] s_reg;
  logic [1:0] c_reg;
  logic [CW-1:0] w_reg;
  logic rv_reg;
  logic [DEV_AW-1:0] rv_addr_reg;
  logic [DEV_AW-1:0] land_addr_reg;

  // ==========================================
  // Range arithmetic
  logic [CW-1:0] cnt;
  logic [OW-1:0] sbase;
  logic [OW-1:0] dbase;
  logic [OW-1:0] all_sum;
  logic [NCPU-1:0][OW-1:0] cpu_sum;
  logic cfg_bad;
  logic is_mirror;
  logic [DEV_AW-1:0] cpu_addr;
  logic [OW-1:0] lo;
  logic [OW-1:0] run;
  logic [OW-1:0] sh;
  logic [1:0] cfg_sel;

  assign cpu_addr = reg_addr_i[DEV_AW-1:0];
  assign cfg_sel = 2'(reg_addr_i[15:CFG_SHIFT] - A_CFG[15:CFG_SHIFT]);

  // Offsets of the current setting and CPU, totals and mirror decode
  always_comb begin
    cnt = cfg_reg[s_reg].cnt[c_reg];
    sbase = '0;
    dbase = '0;
    all_sum = '0;
    cpu_sum = '0;
    cfg_bad = 1'b0;
    is_mirror = 1'b0;
    sh = '0;
    for (int s = 0; s < NSET; s++) begin
      lo = cfg_reg[s].is_bit ? OW'(cfg_reg[s].base >> BIT_SHIFT) : cfg_reg[s].base[OW-1:0];
      if (cfg_reg[s].is_bit && (cfg_reg[s].base[3:0] & BIT_ALIGN) != 4'h0) begin
        cfg_bad = 1'b1;
      end
      run = lo;
      for (int c = 0; c < NCPU; c++) begin
        if (cfg_reg[s].cnt[c][0]) begin
          cfg_bad = 1'b1;
        end
        if (s == 32'(s_reg) && c == 32'(c_reg)) begin
          sbase = sh;
          dbase = run;
        end
        if (c != SELF && cfg_reg[s].cnt[c] != '0 && OW'(cpu_addr) >= run
            && OW'(cpu_addr) < run + OW'(cfg_reg[s].cnt[c])) begin
          is_mirror = 1'b1;
        end
        run = run + OW'(cfg_reg[s].cnt[c]);
        sh = sh + OW'(cfg_reg[s].cnt[c]);
        cpu_sum[c] = cpu_sum[c] + OW'(cfg_reg[s].cnt[c]);
      end
    end
    all_sum = sh;
    for (int c = 0; c < NCPU; c++) begin
      if (cpu_sum[c] > MAX_CPU_WORDS) begin
        cfg_bad = 1'b1;
      end
      if (c != SELF && peer_sum_i[c] != all_sum) begin
        cfg_bad = 1'b1;
      end
    end
    if (all_sum > MAX_ALL_WORDS) begin
      cfg_bad = 1'b1;
    end
  end

  // ==========================================
  // Engine control
  logic go;
  logic at_end;
  logic last;
  logic own_fire;
  logic req_fire;

  assign go = refresh_slot_i && enable_reg && !halt_i && !param_err_o;
  assign at_end = w_reg == cnt;
  assign last = s_reg == 2'(NSET - 1) && c_reg == 2'(NCPU - 1);
  assign own_fire = state_reg == ST_WALK && !at_end && 32'(c_reg) == SELF;
  assign req_fire = state_reg == ST_WALK && !at_end && 32'(c_reg) != SELF
                    && !peer_halt_i[c_reg];

  // Walk settings and CPUs in order, word by word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      s_reg <= 2'h0;
      c_reg <= 2'h0;
      w_reg <= '0;
    end else if (halt_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            state_reg <= ST_WALK;
            s_reg <= 2'h0;
            c_reg <= 2'h0;
            w_reg <= '0;
          end
        end
        ST_WALK: begin
          if (at_end || (32'(c_reg) != SELF && peer_halt_i[c_reg])) begin
            w_reg <= '0;
            c_reg <= c_reg + 2'h1;
            if (c_reg == 2'(NCPU - 1)) begin
              s_reg <= s_reg + 2'h1;
            end
            if (last) begin
              state_reg <= ST_DRAIN;
            end
          end else begin
            w_reg <= w_reg + CW'(1);
          end
        end
        ST_DRAIN: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Publish own range into own shared area
  always_ff @(posedge clk_i) begin
    if (own_fire && !halt_i) begin
      shm_mem[SHM_AW'(sbase + OW'(w_reg))] <= dev_mem[DEV_AW'(dbase + OW'(w_reg))];
    end
  end

  // Lock own area while it is being rewritten
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shm_lock_o <= 1'b0;
    end else begin
      shm_lock_o <= state_reg == ST_WALK && 32'(c_reg) == SELF && !halt_i;
    end
  end

  // Read request towards a peer shared area; its answer is written two edges after issue
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      peer_req_o <= '0;
      rv_reg <= 1'b0;
      rv_addr_reg <= '0;
      land_addr_reg <= '0;
    end else begin
      peer_req_o.rd <= req_fire && !halt_i;
      peer_req_o.cpu <= c_reg;
      peer_req_o.addr <= sbase + OW'(w_reg);
      rv_reg <= peer_req_o.rd;
      rv_addr_reg <= DEV_AW'(dbase + OW'(w_reg));
      land_addr_reg <= rv_addr_reg;
    end
  end

  // Device memory: mirror writes from the engine, own writes from software
  always_ff @(posedge clk_i) begin
    if (rv_reg) begin
      dev_mem[land_addr_reg] <= peer_rdata_i;
    end
    if (reg_wr_i && reg_addr_i[DEV_BIT] && !is_mirror) begin
      dev_mem[cpu_addr] <= reg_wdata_i;
    end
  end

  // Peers read own shared area, answer one cycle later
  always_ff @(posedge clk_i) begin
    if (shm_req_i.rd) begin
      shm_rdata_o <= shm_mem[SHM_AW'(shm_req_i.addr)];
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_reg <= 1'b0;
      for (int s = 0; s < NSET; s++) begin
        cfg_reg[s] <= '0;
      end
    end else if (reg_wr_i && !reg_addr_i[DEV_BIT]) begin
      if (reg_addr_i == A_CTRL) begin
        enable_reg <= reg_wdata_i[0];
      end
      for (int s = 0; s < NSET; s++) begin
        if (reg_addr_i[15:CFG_SHIFT] == A_CFG[15:CFG_SHIFT] + 13'(s)) begin
          case (reg_addr_i[CFG_SHIFT-1:0])
            3'h0: begin
              cfg_reg[s].is_bit <= reg_wdata_i[C_KIND];
              cfg_reg[s].base <= reg_wdata_i[OW:0];
            end
            3'h1, 3'h2, 3'h3, 3'h4: begin
              cfg_reg[s].cnt[reg_addr_i[1:0] - 2'h1] <= reg_wdata_i[CW-1:0];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Rejected mirror write flag, set wins over clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wrej_reg <= 1'b0;
    end else if (reg_wr_i && reg_addr_i[DEV_BIT] && is_mirror) begin
      wrej_reg <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == A_STAT && reg_wdata_i[S_WREJ]) begin
      wrej_reg <= 1'b0;
    end
  end

  // Status outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      param_err_o <= 1'b0;
      peer_halt_flag_o <= '0;
    end else begin
      busy_o <= state_reg != ST_IDLE;
      param_err_o <= cfg_bad;
      peer_halt_flag_o <= peer_halt_i;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i[DEV_BIT]) begin
        reg_rdata_o <= dev_mem[cpu_addr];
      end else if (reg_addr_i == A_CTRL) begin
        reg_rdata_o <= {15'h0000, enable_reg};
      end else if (reg_addr_i == A_STAT) begin
        reg_rdata_o <= {8'h00, peer_halt_flag_o, 1'b0, wrej_reg, param_err_o, busy_o};
      end else if (reg_addr_i[15:CFG_SHIFT] - A_CFG[15:CFG_SHIFT] < 13'(NSET)) begin
        case (reg_addr_i[CFG_SHIFT-1:0])
          3'h0: reg_rdata_o <= {cfg_reg[cfg_sel].is_bit, cfg_reg[cfg_sel].base};
          3'h1, 3'h2, 3'h3, 3'h4: reg_rdata_o <= 16'(cfg_reg[cfg_sel].cnt[reg_addr_i[1:0] - 2'h1]);
          default: reg_rdata_o <= 16'h0000;
        endcase
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

  // ==========================================
  // Assertions
  sequence s_issue;
    req_fire && !halt_i;
  endsequence
  sequence s_land;
    peer_req_o.rd ##1 rv_reg;
  endsequence
  a_req_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    s_issue |=> s_land)
    else $error("peer read did not land");
  a_halt_stops: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_i |=> state_reg == ST_IDLE && !peer_req_o.rd)
    else $error("halt did not stop refresh");
  a_peer_halt_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_WALK && 32'(c_reg) != SELF && peer_halt_i[c_reg] |=> !peer_req_o.rd)
    else $error("halted peer was read");

  a_zero_count: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_WALK && cnt == '0 |-> !own_fire && !req_fire)
    else $error("zero count moved data");

  a_slot_start: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_IDLE && go |=> state_reg == ST_WALK ##1 busy_o)
    else $error("slot did not start refresh");

  a_no_start_err: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_IDLE && param_err_o |=> state_reg == ST_IDLE)
    else $error("refresh ran with parameter error");

  a_mirror_reject: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i[DEV_BIT] && is_mirror |=> wrej_reg)
    else $error("mirror write not flagged");

  a_own_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    own_fire && !halt_i |=> shm_lock_o)
    else $error("own area written unlocked");

  a_drain_end: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_WALK && last && at_end && !halt_i
    |=> state_reg == ST_DRAIN ##1 state_reg == ST_IDLE)
    else $error("walk did not end after fourth setting");
endmodule
`default_nettype wire

/* verification/smr_peer_model.sv */
// Peer CPU shared areas answering the engine's read requests
`timescale 1ns/1ns
`default_nettype none
module smr_peer_model
  import smr_pkg::*;
(
  input wire logic clk_i,
  input wire smr_req_s req_i,
  input wire logic [NCPU-1:0] halt_i,
  input wire logic [3:0] gen_i,
  output logic [15:0] rdata_o
);
  // ==========
  // Answer path
  // ==========
  // Word of a live peer the cycle after rd; otherwise the bus toggles so stale data never passes
  initial rdata_o = 16'h0000;
  always @(posedge clk_i) begin
    if (req_i.rd && !halt_i[req_i.cpu]) begin
      rdata_o <= {req_i.cpu, req_i.addr} ^ {gen_i, 12'h000};
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

/* verification/test_shared_memory_auto_refresh.sv */
// Self-checking bench for the shared memory refresh engine
`timescale 1ns/1ns
`default_nettype none
module test_shared_memory_auto_refresh;
  import smr_pkg::*;
  logic clk_i, rst_i, reg_wr_i, reg_rd_i, refresh_slot_i, halt_i;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, peer_rdata_i, shm_rdata_o, r;
  logic [NCPU-1:0] peer_halt_i, peer_halt_flag_o;
  logic [NCPU-1:0][OW-1:0] peer_sum_i;
  smr_req_s peer_req_o, shm_req_i;
  logic shm_lock_o, busy_o, param_err_o, seen, lk;
  logic [3:0] gen;
  int n_fail, n_compared;
  // ==========
  // Design and peers
  // ==========
  smr_engine uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .refresh_slot_i(refresh_slot_i),
    .halt_i(halt_i),
    .peer_halt_i(peer_halt_i),
    .peer_sum_i(peer_sum_i),
    .peer_req_o(peer_req_o),
    .peer_rdata_i(peer_rdata_i),
    .shm_req_i(shm_req_i),
    .shm_rdata_o(shm_rdata_o),
    .shm_lock_o(shm_lock_o),
    .peer_halt_flag_o(peer_halt_flag_o),
    .busy_o(busy_o),
    .param_err_o(param_err_o)
  );
  smr_peer_model peers (
    .clk_i(clk_i),
    .req_i(peer_req_o),
    .halt_i(peer_halt_i),
    .gen_i(gen),
    .rdata_o(peer_rdata_i)
  );
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ==========
  // Tasks
  // ==========
  function automatic logic [15:0] pd(input logic [1:0] c, input logic [13:0] a,
    input logic [3:0] g);
    return {c, a} ^ {g, 12'h000};
  endfunction
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 r = reg_rdata_o;
  endtask
  task automatic chkdev(input logic [11:0] w, input logic [15:0] e);
    rd(16'h8000 | {4'h0, w});
    chk($sformatf("device word %h", w), r, e);
  endtask
  task automatic chkshm(input logic [13:0] a, input logic [15:0] e);
    @(posedge clk_i);
    shm_req_i <= '{1'b1, 2'd1, a};
    @(posedge clk_i);
    shm_req_i.rd <= 1'b0;
    #1 chk($sformatf("shared word %h", a), shm_rdata_o, e);
  endtask
  task automatic cfg(input int s, input logic [15:0] w0, input logic [11:0] c [4]);
    logic [15:0] b;
    b = A_CFG + 16'(s << CFG_SHIFT);
    wr(b, w0);
    for (int i = 0; i < 4; i++) wr(b + 16'(i + 1), {4'h0, c[i]});
  endtask
  task automatic sums(input logic [13:0] t);
    @(posedge clk_i);
    for (int i = 0; i < NCPU; i++) peer_sum_i[i] <= t;
  endtask
  // Word setting with an idle CPU3, bit setting at bit 32, two empty settings
  task automatic good();
    cfg(0, 16'h0100, '{12'h2, 12'h2, 12'h0, 12'h2});
    cfg(1, 16'h8020, '{12'h2, 12'h2, 12'h0, 12'h0});
    cfg(2, 16'h0000, '{12'h0, 12'h0, 12'h0, 12'h0});
    sums(14'h000a);
  endtask
  task automatic refresh();
    seen = 1'b0;
    lk = 1'b0;
    @(posedge clk_i);
    refresh_slot_i <= 1'b1;
    @(posedge clk_i);
    refresh_slot_i <= 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_i);
      #1 lk = lk | (shm_lock_o === 1'b1);
      if (busy_o === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    chk("busy seen", {15'h0, seen}, 16'h0001);
    chk("lock seen", {15'h0, lk}, 16'h0001);
  endtask
  task automatic noslot();
    @(posedge clk_i);
    refresh_slot_i <= 1'b1;
    @(posedge clk_i);
    refresh_slot_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk("busy idle", {15'h0, busy_o}, 16'h0000);
  endtask
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========
  // Tests
  // ==========
  // Watchdog
  initial begin
    #(50 * 20000);
    n_fail++;
    $display("[ERR] watchdog expired");
    print_verdict();
  end
  // Main sequence
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, refresh_slot_i, halt_i} = 5'b10000;
    {reg_addr_i, reg_wdata_i, peer_halt_i, gen} = '0;
    peer_sum_i = '0;
    shm_req_i = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_STAT);
    chk("status after reset", r, 16'h0000);
    good();
    wr(16'h8100, 16'h1111);
    wr(16'h8101, 16'h2222);
    wr(16'h8002, 16'h3333);
    wr(16'h8003, 16'h4444);
    wr(16'h8106, 16'hbeef);
    wr(A_CTRL, 16'h0001);
    rd(A_CTRL);
    chk("enable", r, 16'h0001);
    rd(A_CFG + 16'h0008);
    chk("setting 1 start", r, 16'h8020);
    rd(A_CFG + 16'h0004);
    chk("setting 0 count 4", r, 16'h0002);
    repeat (4) @(posedge clk_i);
    #1 chk("busy without slot", {15'h0, busy_o}, 16'h0000);
    refresh();
    chkshm(14'h0000, 16'h1111);
    chkshm(14'h0001, 16'h2222);
    chkshm(14'h0006, 16'h3333);
    chkshm(14'h0007, 16'h4444);
    chkdev(12'h102, pd(2'd1, 14'h0002, 4'h0));
    chkdev(12'h103, pd(2'd1, 14'h0003, 4'h0));
    chkdev(12'h104, pd(2'd3, 14'h0004, 4'h0));
    chkdev(12'h105, pd(2'd3, 14'h0005, 4'h0));
    chkdev(12'h004, pd(2'd1, 14'h0008, 4'h0));
    chkdev(12'h005, pd(2'd1, 14'h0009, 4'h0));
    chkdev(12'h106, 16'hbeef);
    $display("test refresh done");
    // CPU4 halts and the peers publish new data
    @(posedge clk_i);
    peer_halt_i <= 4'b1000;
    gen <= 4'h1;
    refresh();
    chk("halt flags", {12'h0, peer_halt_flag_o}, 16'h0008);
    rd(A_STAT);
    chk("status halt", r, 16'h0080);
    chkdev(12'h102, pd(2'd1, 14'h0002, 4'h1));
    chkdev(12'h104, pd(2'd3, 14'h0004, 4'h0));
    chkdev(12'h105, pd(2'd3, 14'h0005, 4'h0));
    @(posedge clk_i);
    peer_halt_i <= 4'b0000;
    halt_i <= 1'b1;
    noslot();
    @(posedge clk_i);
    halt_i <= 1'b0;
    $display("test halt done");
    // Mirror words refuse local writes, own words accept them
    wr(16'h8102, 16'hdead);
    chkdev(12'h102, pd(2'd1, 14'h0002, 4'h1));
    rd(A_STAT);
    chk("reject flag", r & 16'h0004, 16'h0004);
    wr(A_STAT, 16'h0004);
    rd(A_STAT);
    chk("reject cleared", r & 16'h0004, 16'h0000);
    wr(16'h8101, 16'h5555);
    chkdev(12'h101, 16'h5555);
    $display("test access done");
    // Each bad setting or mismatching peer total raises the error and blocks refresh until repaired
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      case (k)
        0: cfg(1, 16'h8021, '{12'h2, 12'h2, 12'h0, 12'h0});
        1: begin
          cfg(1, 16'h8020, '{12'h3, 12'h2, 12'h0, 12'h0});
          sums(14'h000b);
        end
        2: peer_sum_i[2] <= 14'h000b;
        default: begin
          cfg(2, 16'h0200, '{12'h7fe, 12'h0, 12'h0, 12'h0});
          sums(14'h0808);
        end
      endcase
      repeat (3) @(posedge clk_i);
      #1 chk("param error set", {15'h0, param_err_o}, 16'h0001);
      noslot();
      good();
      repeat (3) @(posedge clk_i);
      #1 chk("param error clear", {15'h0, param_err_o}, 16'h0000);
    end
    $display("test parameter errors done");
    print_verdict();
  end
endmodule
`default_nettype wire
